/* File: verilog/conv_serial_input.sv */
// Serial input logic of a dual-channel 16-bit converter: shift register,
// two input registers, two converter registers and a code reset.
// Assumes the serial clock is source-synchronous with chip select and
// data, and that the strobe and reset pins are asynchronous to clk_sys.
//
// Function
// - Each command is exactly 24 serial bits.
// - Last 16 bits are the code, MSB first.
// - First bit picks channel written by latch strobe.
// - Broadcast bit high writes both input registers.
// - Broadcast bit low writes only the selected register.
// - Second bit and five filler bits are ignored.
// - Reset forces all codes to 8000 or 0000.
// - Reset acts on rising edge, independent of serial clock.
// - Chip select low gates shifting.
// - Shift one bit per rising serial clock edge.
// - Update rising edge copies both input registers.
// - Serial output is the shift register's last bit.
`timescale 1ns/1ps
module conv_serial_input
    import conv_serial_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial link
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialIn,
    output logic serialOut,
    // Strobes and reset pins
    input wire logic loadStrobeN,
    input wire logic outputUpdateStrobe,
    input wire logic codeResetTrigger,
    input wire logic resetLevelSelect,
    // Register contents
    output logic [CODE_BITS-1:0] inputCodeA,
    output logic [CODE_BITS-1:0] inputCodeB,
    output logic [CODE_BITS-1:0] outputCodeA,
    output logic [CODE_BITS-1:0] outputCodeB,
    // Room for another frame
    output logic cmdSpace
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: reset synchroniser and shift register

    logic [1:0] linkRst_q;
    word_t shiftReg_q, shiftReg_d;
    logic shiftNext;

    // rst_n crosses in; first stage feeds only the second
    always_ff @(posedge serialClk) begin
        linkRst_q <= {linkRst_q[0], rst_n};
    end

    // Only system reset clears the shift register, never a code reset;
    // the clear waits for select high, so the slow release of the link
    // reset never swallows the first bits of a frame
    always_comb begin
        shiftReg_d = shiftReg_q;
        if (!linkRst_q[1] && chipSelN) begin
            shiftReg_d = SHIFT_RESET;
        end else if (!chipSelN) begin
            // New bit enters at the bottom, MSB leaves first
            shiftReg_d = {shiftReg_q[WORD_BITS-2:0], serialIn};
        end
    end

    always_ff @(posedge serialClk) begin
        shiftReg_q <= shiftReg_d;
    end

    // Driven from the top flop, so a daisy-chained part can take it
    assign serialOut = shiftReg_q[WORD_BITS-1];
    assign shiftNext = shiftReg_q[WORD_BITS-2];

    ////////////////////////////////////////////////////////////////////////
    // System domain: pin synchronisers and edge detection

    logic [PIN_COUNT-1:0] pinRaw, pinMeta_q, pinSync_q, pinPrev_q;
    logic csRise, loadActive, updRise, trigRise, levelHigh;

    assign pinRaw[PIN_CS] = chipSelN;
    assign pinRaw[PIN_LOAD] = loadStrobeN;
    assign pinRaw[PIN_UPDATE] = outputUpdateStrobe;
    assign pinRaw[PIN_TRIGGER] = codeResetTrigger;
    assign pinRaw[PIN_LEVEL] = resetLevelSelect;

    // Two stages, then a third only for edge detection
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pinMeta_q <= PIN_IDLE;
            pinSync_q <= PIN_IDLE;
            pinPrev_q <= PIN_IDLE;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // Edge detectors look at stages two and three only
    assign csRise = pinSync_q[PIN_CS] && !pinPrev_q[PIN_CS];
    assign loadActive = !pinSync_q[PIN_LOAD];
    assign updRise = pinSync_q[PIN_UPDATE] && !pinPrev_q[PIN_UPDATE];
    assign trigRise = pinSync_q[PIN_TRIGGER] && !pinPrev_q[PIN_TRIGGER];
    assign levelHigh = pinSync_q[PIN_LEVEL];

    ////////////////////////////////////////////////////////////////////////
    // Frame capture into the command FIFO

    logic fifoValid, popReq;
    word_t fifoWord;
    code_t fifoCode;
    logic wordBroadcast, wordChanSel;

    // The shift register is read only after chip select has been seen
    // high for two clk_sys edges; no shift can occur then, so it is
    // quasi-static. A late clock-low rise is not turned into a shift.
    word_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inValid(csRise),
        .inReady(cmdSpace),
        .inData(shiftReg_q),
        .outValid(fifoValid),
        .outReady(popReq),
        .outData(fifoWord)
    );

    // A pending code reset holds the queue so no word is half-applied
    assign popReq = loadActive && !trigRise;

    // Field split; bit 22 and bits 20..16 are never looked at
    assign wordChanSel = fifoWord[CHAN_SEL_POS];
    assign wordBroadcast = fifoWord[BROADCAST_POS];
    assign fifoCode = fifoWord[CODE_BITS-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Input and converter registers

    code_t inA_q, inA_d, inB_q, inB_d;
    code_t convA_q, convA_d, convB_q, convB_d;
    code_t resetCode;
    logic popNow;

    assign popNow = popReq && fifoValid;
    assign resetCode = levelHigh ? CODE_MID_SCALE : CODE_ZERO_SCALE;

    // Code reset wins over load and update in the same cycle
    always_comb begin
        inA_d = inA_q;
        inB_d = inB_q;
        convA_d = convA_q;
        convB_d = convB_q;
        if (trigRise) begin
            inA_d = resetCode;
            inB_d = resetCode;
            convA_d = resetCode;
            convB_d = resetCode;
        end else begin
            if (popNow) begin
                if (wordBroadcast) begin
                    inA_d = fifoCode;
                    inB_d = fifoCode;
                end else if (wordChanSel) begin
                    inB_d = fifoCode;
                end else begin
                    inA_d = fifoCode;
                end
            end
            // Takes the values held before any same-cycle load
            if (updRise) begin
                convA_d = inA_q;
                convB_d = inB_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            inA_q <= SYS_RESET_CODE;
            inB_q <= SYS_RESET_CODE;
            convA_q <= SYS_RESET_CODE;
            convB_q <= SYS_RESET_CODE;
        end else begin
            inA_q <= inA_d;
            inB_q <= inB_d;
            convA_q <= convA_d;
            convB_q <= convB_d;
        end
    end

    assign inputCodeA = inA_q;
    assign inputCodeB = inB_q;
    assign outputCodeA = convA_q;
    assign outputCodeB = convB_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions, link domain

    property p_shift_gate;
        @(posedge serialClk) disable iff (!linkRst_q[1])
        chipSelN |=> $stable(shiftReg_q);
    endproperty
    a_shift_gate: assert property (p_shift_gate)
        else $error("shift register moved with chip select high");

    property p_shift_in;
        @(posedge serialClk) disable iff (!linkRst_q[1])
        !chipSelN |=> shiftReg_q[0] == $past(serialIn);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("serial input bit not shifted in");

    property p_chain_out;
        @(posedge serialClk) disable iff (!linkRst_q[1])
        !chipSelN |=> serialOut == $past(shiftNext);
    endproperty
    a_chain_out: assert property (p_chain_out)
        else $error("serial output is not the advancing top bit");

    ////////////////////////////////////////////////////////////////////////
    // Assertions, system domain

    property p_reset_mid;
        @(posedge clk_sys) disable iff (!rst_n)
        trigRise && levelHigh |=> inA_q == 16'h8000 && inB_q == 16'h8000
            && convA_q == 16'h8000 && convB_q == 16'h8000;
    endproperty
    a_reset_mid: assert property (p_reset_mid)
        else $error("mid-scale reset not applied to all registers");

    property p_reset_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        trigRise && !levelHigh |=> inA_q == 16'h0000 && inB_q == 16'h0000
            && convA_q == 16'h0000 && convB_q == 16'h0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("zero-scale reset not applied to all registers");

    // Synchronised edge to register change, seen from the flops
    property p_trigger_latency;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(pinSync_q[PIN_TRIGGER]) && !levelHigh
            |=> convA_q == 16'h0000 && convB_q == 16'h0000;
    endproperty
    a_trigger_latency: assert property (p_trigger_latency)
        else $error("code reset not applied after synchronised edge");

    property p_update;
        @(posedge clk_sys) disable iff (!rst_n)
        updRise && !trigRise |=> convA_q == $past(inA_q)
            && convB_q == $past(inB_q);
    endproperty
    a_update: assert property (p_update)
        else $error("update edge did not copy both input registers");

    property p_conv_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !updRise && !trigRise |=> $stable(convA_q) && $stable(convB_q);
    endproperty
    a_conv_hold: assert property (p_conv_hold)
        else $error("converter register changed without an update edge");

    property p_broadcast;
        @(posedge clk_sys) disable iff (!rst_n)
        popNow && wordBroadcast |=> inA_q == $past(fifoCode)
            && inB_q == $past(fifoCode);
    endproperty
    a_broadcast: assert property (p_broadcast)
        else $error("broadcast word did not reach both input registers");

    property p_select_first;
        @(posedge clk_sys) disable iff (!rst_n)
        popNow && !wordBroadcast && !wordChanSel
            |=> inA_q == $past(fifoCode) && $stable(inB_q);
    endproperty
    a_select_first: assert property (p_select_first)
        else $error("channel zero word misrouted");

    property p_select_second;
        @(posedge clk_sys) disable iff (!rst_n)
        popNow && !wordBroadcast && wordChanSel
            |=> inB_q == $past(fifoCode) && $stable(inA_q);
    endproperty
    a_select_second: assert property (p_select_second)
        else $error("channel one word misrouted");

    property p_no_stray_write;
        @(posedge clk_sys) disable iff (!rst_n)
        !popNow && !trigRise |=> $stable(inA_q) && $stable(inB_q);
    endproperty
    a_no_stray_write: assert property (p_no_stray_write)
        else $error("input register changed without a load");

    property p_frame_queued;
        @(posedge clk_sys) disable iff (!rst_n)
        csRise && cmdSpace && !popReq |=> fifoValid;
    endproperty
    a_frame_queued: assert property (p_frame_queued)
        else $error("completed frame was not queued");

endmodule

/* File: inc/conv_serial_pkg.sv */
// Shared constants and types for the dual-channel serial input logic.
// Assumes a 24-bit command word with the code in the low 16 bits.
package conv_serial_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command word layout
    localparam int WORD_BITS = 24;
    localparam int CODE_BITS = 16;
    localparam int CHAN_SEL_POS = 23;
    localparam int BROADCAST_POS = 21;

    ////////////////////////////////////////////////////////////////////////
    // Buffering between serial frames and the latch strobe
    localparam int FIFO_DEPTH = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] CODE_MID_SCALE = 16'h8000;
    localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
    localparam logic [15:0] SYS_RESET_CODE = 16'h0000;
    localparam logic [23:0] SHIFT_RESET = 24'h000000;
    localparam logic [1:0] LINK_RST_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Synchronised pin vector: bit positions and idle levels
    localparam int PIN_COUNT = 5;
    localparam int PIN_CS = 0;
    localparam int PIN_LOAD = 1;
    localparam int PIN_UPDATE = 2;
    localparam int PIN_TRIGGER = 3;
    localparam int PIN_LEVEL = 4;
    localparam logic [4:0] PIN_IDLE = 5'h03;

    typedef logic [CODE_BITS-1:0] code_t;
    typedef logic [WORD_BITS-1:0] word_t;

endpackage

/* File: verilog/word_fifo.sv */
// Synchronous word FIFO with valid/ready on both sides.
// Assumes one clock for both sides and a power-of-two depth.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [PW:0] count_q, count_d;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshake terms; full and empty come straight from the count
    assign inReady = count_q != (PW+1)'(DEPTH);
    assign outValid = count_q != '0;
    assign outData = mem_q[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and occupancy next values
    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            wrPtr_d = wrPtr_q + 1'b1; // Wraps, depth is a power of two
        end
        if (pop) begin
            rdPtr_d = rdPtr_q + 1'b1;
        end
        unique case ({push, pop})
            2'b10: count_d = count_q + 1'b1;
            2'b01: count_d = count_q - 1'b1;
            default: count_d = count_q;
        endcase
    end

    // Storage has no reset; only pointers and count need a known value
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

endmodule

/* File: verification/conv_host_model.sv */
// Host side of the serial link: drives clock, select and data of frames.
// Assumes the bench calls its tasks; the link clock stays high between
// frames and is offset in phase from the system clock.
`timescale 1ns/1ps
module conv_host_model
    import conv_serial_pkg::*;
(
    // Serial link towards the device
    output logic serialClk,
    output logic chipSelN,
    output logic serialIn
);

    ////////////////////////////////////////////////////////////////////////
    // Half of the 15 ns link period
    localparam realtime HALF = 7.5;

    // Idle high, so that raising the select never adds a shift
    initial begin
        serialClk = 1'b1;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock pulses with select high; data wanders, nothing may be taken
    task automatic idle_clocks(input int n);
        #1.3;
        for (int i = 0; i < n; i++) begin
            serialClk = 1'b0;
            serialIn = ~serialIn;
            #HALF;
            serialClk = 1'b1;
            #HALF;
        end
    endtask

    // One whole command word, top bit first
    task automatic send_word(input word_t w);
        #1.3;
        chipSelN = 1'b0;
        #HALF;
        for (int i = WORD_BITS - 1; i >= 0; i--) begin
            serialClk = 1'b0;
            serialIn = w[i];
            #HALF;
            serialClk = 1'b1;
            #HALF;
        end
        // Select rises only with the clock high
        chipSelN = 1'b1;
        // Released data line must not look like the last bit
        serialIn = ~serialIn;
        #30;
    endtask

endmodule

/* File: verification/dual_dac_serial_input_logic_tb_top.sv */
// Self-checking bench of the converter serial input logic.
// Assumes the host model drives the link; strobes are driven here.
`timescale 1ns/1ps
module dual_dac_serial_input_logic_tb_top
    import conv_serial_pkg::*;
;

    ////////////////////////////////////////////////////////////////////////
    // Signals
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic serialClk, chipSelN, serialIn, serialOut, cmdSpace;
    logic loadStrobeN = 1'b1;
    logic outputUpdateStrobe = 1'b0;
    logic codeResetTrigger = 1'b0;
    logic resetLevelSelect = 1'b0;
    code_t inputCodeA, inputCodeB, outputCodeA, outputCodeB;
    word_t shiftShadow = SHIFT_RESET;
    int miscompares = 0;
    int check_count = 0;

    // System clock, 5 ns period
    always #2.5 clk_sys = ~clk_sys;

    conv_serial_input dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .serialClk(serialClk),
        .chipSelN(chipSelN), .serialIn(serialIn), .serialOut(serialOut),
        .loadStrobeN(loadStrobeN), .outputUpdateStrobe(outputUpdateStrobe),
        .codeResetTrigger(codeResetTrigger),
        .resetLevelSelect(resetLevelSelect), .inputCodeA(inputCodeA),
        .inputCodeB(inputCodeB), .outputCodeA(outputCodeA),
        .outputCodeB(outputCodeB), .cmdSpace(cmdSpace)
    );

    conv_host_model hostU (
        .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic final_report;
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_codes(input code_t a, b, oa, ob);
        chk({8'h00, inputCodeA}, {8'h00, a});
        chk({8'h00, inputCodeB}, {8'h00, b});
        chk({8'h00, outputCodeA}, {8'h00, oa});
        chk({8'h00, outputCodeB}, {8'h00, ob});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Strobes are synchronised, so each level is held well past 3 cycles
    task automatic pulse(ref logic s, input logic act, input int n);
        s = act;
        cycles(n);
        s = ~act;
        cycles(5);
    endtask

    // Frame plus the time it takes to reach the queue
    task automatic frame(input word_t w);
        hostU.send_word(w);
        cycles(6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reference shift register; the code reset must leave it alone
    always @(posedge serialClk)
        if (!chipSelN) shiftShadow <= {shiftShadow[22:0], serialIn};

    // Top bit compared mid-period, well clear of the shifting edge
    always @(negedge serialClk)
        if (rst_n === 1'b1 && chipSelN === 1'b0)
            chk({23'h0, serialOut}, {23'h0, shiftShadow[23]});

    // Watchdog, far beyond the expected run of about 6 us
    initial begin
        #100000;
        miscompares++;
        final_report;
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        // Link clock pulses during reset so the link side clears too
        fork
            hostU.idle_clocks(3);
            cycles(12);
        join
        rst_n = 1'b1;
        cycles(4);
        chk_codes(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk({23'h0, cmdSpace}, 24'h000001);
        // Channel A with every ignored bit set
        frame(24'h5F1234);
        pulse(loadStrobeN, 1'b0, 4);
        chk_codes(16'h1234, 16'h0000, 16'h0000, 16'h0000);
        frame(24'h80ABCD);
        pulse(loadStrobeN, 1'b0, 4);
        chk_codes(16'h1234, 16'hABCD, 16'h0000, 16'h0000);
        pulse(outputUpdateStrobe, 1'b1, 4);
        chk_codes(16'h1234, 16'hABCD, 16'h1234, 16'hABCD);
        // Broadcast with channel bit high still writes both
        frame(24'hA05A5A);
        pulse(loadStrobeN, 1'b0, 4);
        chk_codes(16'h5A5A, 16'h5A5A, 16'h1234, 16'hABCD);
        // Code reset to mid-scale with the link clock stopped
        resetLevelSelect = 1'b1;
        cycles(3);
        pulse(codeResetTrigger, 1'b1, 4);
        chk_codes(16'h8000, 16'h8000, 16'h8000, 16'h8000);
        // Clocks with select high must not shift
        hostU.idle_clocks(5);
        resetLevelSelect = 1'b0;
        cycles(3);
        pulse(codeResetTrigger, 1'b1, 4);
        chk_codes(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        // Fill the queue past its depth while the latch strobe stalls
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            frame(word_t'(i + 1));
            chk({23'h0, cmdSpace}, {23'h0, (i + 1 < FIFO_DEPTH)});
        end
        // Drain: one word a cycle, the refused ninth never appears
        pulse(loadStrobeN, 1'b0, FIFO_DEPTH + 4);
        chk_codes(16'h0008, 16'h0000, 16'h0000, 16'h0000);
        chk({23'h0, cmdSpace}, 24'h000001);
        pulse(outputUpdateStrobe, 1'b1, 4);
        chk_codes(16'h0008, 16'h0000, 16'h0008, 16'h0000);
        final_report;
    end

endmodule
